// [core/flag_bus_controller.sv]
// Purpose: flag monitoring controller reached over Avalon-MM
// Assumes: one device joined through flag_bus_if
// Notes:   every access answers after one wait cycle
module flag_bus_controller
    import flag_bus_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    flag_bus_if.ctl          bus
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic                 polled;
        logic [WQ_ADDR_W-1:0] wAddr;
        logic [RQ_ADDR_W-1:0] rAddr;
        logic                 wEn;
        logic                 full_bus_strobe;
        logic                 empty_bus_strobe;
        logic                 selAged;
        logic [QUEUES-1:0]    afSnap;
        logic [QUEUES-1:0]    aeSnap;
    } ctl_state_s;

    ctl_state_s state_q;
    ctl_state_s state_d;

    logic        doWrite;
    logic        strobeOk;
    logic        writeOk;
    logic [31:0] status;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        doWrite  = write & state_q.ack & byteenable[0];
        strobeOk = ~state_q.polled & ~bus.serialProgDoneN;
        writeOk  = state_q.selAged & bus.fullLine;
        status   = '0;
        status[ST_FF_BIT]    = bus.fullLine;
        status[ST_WROK_BIT]  = writeOk;
        status[ST_PROGN_BIT] = bus.serialProgDoneN;
        status[ST_FULL_BUS_SYNC_BIT] = bus.fullBusSync;
        status[ST_EMPTY_BUS_SYNC_BIT] = bus.emptyBusSync;
        status[ST_AF_POS +: QUEUES]    = bus.almostFullLine;
        status[ST_AE_POS +: QUEUES]    = bus.almostEmptyLine;
        status[ST_AFSNAP_POS +: QUEUES] = state_q.afSnap;
        status[ST_AESNAP_POS +: QUEUES] = state_q.aeSnap;

        state_d      = state_q;
        state_d.ack  = (read | write) & ~state_q.ack;
        state_d.wEn  = 1'b0;
        state_d.full_bus_strobe = 1'b0;
        state_d.empty_bus_strobe = 1'b0;
        state_d.selAged = state_q.selAged | state_q.wEn;

        if (read & ~state_q.ack) begin
            case (address)
                REG_CTRL:   state_d.rdata = {31'h0, state_q.polled};
                REG_WSEL:   state_d.rdata = {27'h0, state_q.wAddr};
                REG_STATUS: state_d.rdata = status;
                default:    state_d.rdata = '0;
            endcase
        end

        if (doWrite) begin
            case (address)
                REG_CTRL: state_d.polled = writedata[CTRL_POLLED_BIT];
                REG_WSEL: begin
                    state_d.wAddr   = writedata[WQ_ADDR_W-1:0];
                    state_d.wEn     = 1'b1;
                    state_d.selAged = 1'b0;
                end
                REG_FSEL: begin
                    if (strobeOk) begin
                        state_d.wAddr = {writedata[DEV_ID_W-1:0], state_q.wAddr[WQ_SEL_W-1:0]};
                        state_d.full_bus_strobe  = 1'b1;
                    end
                end
                REG_ESEL: begin
                    if (strobeOk) begin
                        state_d.rAddr = {writedata[DEV_ID_W-1:0], {RQ_SEL_W{1'b0}}};
                        state_d.empty_bus_strobe  = 1'b1;
                    end
                end
                default: state_d.polled = state_q.polled;
            endcase
        end

        if (bus.fullBusSync) begin
            state_d.afSnap = bus.almostFullLine;
        end
        if (bus.emptyBusSync) begin
            state_d.aeSnap = bus.almostEmptyLine;
        end

        if (rst) begin
            state_d = '0;
            state_d.polled = RST_POLLED;
            state_d.afSnap = RST_BUS;
            state_d.aeSnap = RST_BUS;
        end
    end

    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign waitrequest         = (read | write) & ~state_q.ack;
    assign readdata            = state_q.rdata;
    assign bus.flagBusModeSel  = state_q.polled;
    assign bus.writeQueueAddr  = state_q.wAddr;
    assign bus.writeAddrEnable = state_q.wEn;
    assign bus.fullBusStrobe   = state_q.full_bus_strobe;
    assign bus.readQueueAddr   = state_q.rAddr;
    assign bus.emptyBusStrobe  = state_q.empty_bus_strobe;
    // single device: loop tokens back in polled mode, tie low in direct
    assign bus.fullTokenIn     = state_q.polled & bus.fullTokenOut;
    assign bus.emptyTokenIn    = state_q.polled & bus.emptyTokenOut;

endmodule

// [core/flag_bus_device.sv]
// Purpose: flag output logic of one multi-queue device
// Assumes: queue status inputs come from logic on clk
// Notes:   master reset is rst; mode, id and master strap latched while rst is high
module flag_bus_device
    import flag_bus_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [DEV_ID_W-1:0] deviceId,
    input  wire logic              isMaster,
    input  wire logic              progDone,
    input  wire logic [QUEUES-1:0] queueFullN,
    input  wire logic [QUEUES-1:0] queueAlmostFullN,
    input  wire logic [QUEUES-1:0] queueAlmostEmptyN,
    flag_bus_if.dev                bus
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                polled;
        logic                master;
        logic [DEV_ID_W-1:0] id;
        logic                inject;
        logic                wrSel;
        logic [WQ_SEL_W-1:0] wrQueue;
        logic                ffOut;
        logic                ffOeN;
        logic                afSel;
        logic                aeSel;
        logic                afOwn;
        logic                aeOwn;
        logic [QUEUES-1:0]   afBus;
        logic                afOeN;
        logic [QUEUES-1:0]   aeBus;
        logic                aeOeN;
        logic                progN;
    } dev_state_s;

    dev_state_s state_q;
    dev_state_s state_d;

    logic                wrHit;
    logic                fullHit;
    logic                emptyHit;
    logic [WQ_SEL_W-1:0] newQueue;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        newQueue = bus.writeQueueAddr[WQ_SEL_W-1:0];
        wrHit    = bus.writeQueueAddr[WQ_ADDR_W-1:WQ_SEL_W] == state_q.id;
        fullHit  = bus.writeQueueAddr[WQ_ADDR_W-1:WQ_SEL_W] == state_q.id;
        emptyHit = bus.readQueueAddr[RQ_ADDR_W-1:RQ_SEL_W] == state_q.id;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d        = state_q;
        state_d.inject = 1'b0;
        state_d.progN  = ~progDone;

        // write queue selection and full flag
        if (bus.writeAddrEnable) begin
            state_d.wrSel   = wrHit;
            state_d.wrQueue = newQueue;
            state_d.ffOut   = queueFullN[newQueue];
        end else begin
            state_d.ffOut   = queueFullN[state_q.wrQueue];
        end
        state_d.ffOeN = ~state_d.wrSel;

        if (state_q.polled) begin
            // token ring: the master injects the first token after reset
            state_d.afOwn = (state_q.inject & state_q.master) | bus.fullTokenIn;
            state_d.aeOwn = (state_q.inject & state_q.master) | bus.emptyTokenIn;
            state_d.afSel = 1'b0;
            state_d.aeSel = 1'b0;
            state_d.afOeN = ~state_d.afOwn;
            state_d.aeOeN = ~state_d.aeOwn;
        end else begin
            // direct: strobe with address picks the owner until the next strobe
            if (bus.fullBusStrobe) begin
                state_d.afSel = fullHit;
            end
            if (bus.emptyBusStrobe) begin
                state_d.aeSel = emptyHit;
            end
            state_d.afOwn = 1'b0;
            state_d.aeOwn = 1'b0;
            state_d.afOeN = ~state_d.afSel;
            state_d.aeOeN = ~state_d.aeSel;
        end
        state_d.afBus = queueAlmostFullN;
        state_d.aeBus = queueAlmostEmptyN;

        if (rst) begin
            state_d.polled  = bus.flagBusModeSel;
            state_d.master  = isMaster;
            state_d.id      = deviceId;
            state_d.inject  = 1'b1;
            state_d.wrSel   = 1'b0;
            state_d.wrQueue = '0;
            state_d.ffOut   = 1'b1;
            state_d.ffOeN   = 1'b1;
            state_d.afSel   = 1'b0;
            state_d.aeSel   = 1'b0;
            state_d.afOwn   = 1'b0;
            state_d.aeOwn   = 1'b0;
            state_d.afBus   = RST_BUS;
            state_d.afOeN   = 1'b1;
            state_d.aeBus   = RST_BUS;
            state_d.aeOeN   = 1'b1;
            state_d.progN   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.writeQueueFullN   = state_q.ffOut;
    assign bus.writeQueueFullOeN = state_q.ffOeN;
    assign bus.almostFullBusN    = state_q.afBus;
    assign bus.almostFullOeN     = state_q.afOeN;
    assign bus.almostEmptyBusN   = state_q.aeBus;
    assign bus.almostEmptyOeN    = state_q.aeOeN;
    assign bus.fullBusSync       = state_q.afOwn;
    assign bus.emptyBusSync      = state_q.aeOwn;
    assign bus.fullTokenOut      = state_q.afOwn;
    assign bus.emptyTokenOut     = state_q.aeOwn;
    assign bus.serialProgDoneN   = state_q.progN;

endmodule

// [dv/flag_bus_asserts.sv]
// Purpose: timing checks on the flag bus between device and controller
// Assumes: one master device with id DEV_ID; rst is the device master reset
// Notes:   instantiated beside the interface, no bind
module flag_bus_asserts
    import flag_bus_pkg::*;
#(
    parameter logic [DEV_ID_W-1:0] DEV_ID = 3'h0
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [WQ_ADDR_W-1:0] writeQueueAddr,
    input wire logic                 writeAddrEnable,
    input wire logic                 fullBusStrobe,
    input wire logic                 emptyBusStrobe,
    input wire logic                 flagBusModeSel,
    input wire logic                 fullTokenIn,
    input wire logic                 emptyTokenIn,
    input wire logic                 writeQueueFullOeN,
    input wire logic                 almostFullOeN,
    input wire logic                 almostEmptyOeN,
    input wire logic                 fullBusSync,
    input wire logic                 emptyBusSync,
    input wire logic                 fullTokenOut,
    input wire logic                 emptyTokenOut,
    input wire logic                 serialProgDoneN
);
    timeunit 1ns;
    timeprecision 100ps;

    wire logic selMe = writeQueueAddr[4:2] == DEV_ID;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_full_drive: assert property (writeAddrEnable && selMe |=> !writeQueueFullOeN)
        else $error("full flag not driven after selection");
    a_full_float: assert property (writeAddrEnable && !selMe |=> writeQueueFullOeN)
        else $error("full flag driven while unselected");
    a_polled_start: assert property ($fell(rst) && flagBusModeSel |=> fullBusSync && emptyBusSync)
        else $error("polled master did not take the buses");
    a_full_bus_sync_token: assert property (fullBusSync |-> fullTokenOut && !almostFullOeN)
        else $error("full sync without token or bus drive");
    a_empty_bus_sync_token: assert property (emptyBusSync |-> emptyTokenOut && !almostEmptyOeN)
        else $error("empty sync without token or bus drive");
    a_ftoken_load: assert property (fullTokenIn |=> fullBusSync)
        else $error("full token not loaded next edge");
    a_etoken_load: assert property (emptyTokenIn |=> emptyBusSync)
        else $error("empty token not loaded next edge");
    a_direct_pick: assert property (fullBusStrobe && selMe |=> !almostFullOeN)
        else $error("strobed device not driving bus");
    a_prog_first: assert property (fullBusStrobe || emptyBusStrobe |-> !serialProgDoneN)
        else $error("strobe before programming done");
    a_polled_nostrobe: assert property (flagBusModeSel |-> !fullBusStrobe && !emptyBusStrobe)
        else $error("strobe in polled mode");

    c_polled: cover property (fullBusSync && emptyBusSync);
    c_direct: cover property (fullBusStrobe && selMe);
    c_other: cover property (writeAddrEnable && !selMe);
endmodule

// [dv/multiqueue_flag_bus_chain_tb.sv]
// Purpose: self-checking bench for the flag bus device and its controller
// Assumes: one master device with id 0, token loopback done by the controller
// Notes:   device reset is pulsed alone to latch a new flag bus mode
module multiqueue_flag_bus_chain_tb
    import flag_bus_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk               = 1'b0;
    logic        rst               = 1'b1;
    logic        devReset          = 1'b0;
    logic        progDone          = 1'b0;
    logic [3:0]  queueFullN        = 4'hf;
    logic [3:0]  queueAlmostFullN  = 4'hf;
    logic [3:0]  queueAlmostEmptyN = 4'hf;
    logic [4:0]  address           = 5'h00;
    logic        read              = 1'b0;
    logic        write             = 1'b0;
    logic [31:0] writedata         = 32'h0;
    logic [3:0]  byteenable        = 4'hf;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [31:0] rd;
    int          errTotal          = 0;
    int          testsRun          = 0;
    wire logic   devRst            = rst | devReset;

    flag_bus_if fb ();

    always #20 clk = ~clk;

    flag_bus_device i_flag_bus_device (
        .clk(clk), .rst(devRst), .deviceId(3'h0), .isMaster(1'b1), .progDone(progDone),
        .queueFullN(queueFullN), .queueAlmostFullN(queueAlmostFullN),
        .queueAlmostEmptyN(queueAlmostEmptyN), .bus(fb)
    );
    flag_bus_controller i_flag_bus_controller (
        .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .bus(fb)
    );
    flag_bus_asserts #(.DEV_ID(3'h0)) i_flag_bus_asserts (
        .clk(clk), .rst(devRst), .writeQueueAddr(fb.writeQueueAddr),
        .writeAddrEnable(fb.writeAddrEnable), .fullBusStrobe(fb.fullBusStrobe),
        .emptyBusStrobe(fb.emptyBusStrobe), .flagBusModeSel(fb.flagBusModeSel),
        .fullTokenIn(fb.fullTokenIn), .emptyTokenIn(fb.emptyTokenIn),
        .writeQueueFullOeN(fb.writeQueueFullOeN), .almostFullOeN(fb.almostFullOeN),
        .almostEmptyOeN(fb.almostEmptyOeN), .fullBusSync(fb.fullBusSync),
        .emptyBusSync(fb.emptyBusSync), .fullTokenOut(fb.fullTokenOut),
        .emptyTokenOut(fb.emptyTokenOut), .serialProgDoneN(fb.serialProgDoneN)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // avalon access; waitrequest is sampled at the rising edge that ends the wait
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d,
                          input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        chk("waitrequest", {31'h0, waitrequest}, 32'h0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        access(1'b1, a, d, 4'hf);
    endtask

    task automatic rdChk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string nm);
        access(1'b0, a, 32'h0, 4'hf);
        chk(nm, rd & m, e);
    endtask

    task automatic dev_pulse();
        @(posedge clk);
        devReset <= 1'b1;
        repeat (3) @(posedge clk);
        devReset <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        rdChk(REG_CTRL, 32'h1, 32'h0, "ctrl mode");
        rdChk(REG_STATUS, 32'hff1f, 32'hff05, "status idle");
        wr(5'h14, 32'hffff_ffff);
        rdChk(5'h14, 32'hffff_ffff, 32'h0, "unmapped");
    endtask

    task automatic test_full();
        for (int q = 0; q < QUEUES; q++) begin
            queueFullN <= ~(4'h1 << q);
            wr(REG_WSEL, 32'(q));
            rdChk(REG_STATUS, 32'h3, 32'h0, "selected full");
            wr(REG_WSEL, 32'((q + 1) % QUEUES));
            rdChk(REG_STATUS, 32'h3, 32'h3, "selected free");
        end
        queueFullN <= 4'h0;
        wr(REG_WSEL, 32'h4);
        rdChk(REG_STATUS, 32'h1, 32'h1, "full floats");
        wr(REG_WSEL, 32'h0);
        rdChk(REG_STATUS, 32'h1, 32'h0, "full drives");
    endtask

    task automatic test_direct();
        queueAlmostFullN <= 4'ha;
        queueAlmostEmptyN <= 4'h5;
        wr(REG_FSEL, 32'h0);
        rdChk(REG_STATUS, 32'hff04, 32'hff04, "strobe early");
        progDone <= 1'b1;
        wr(REG_FSEL, 32'h0);
        wr(REG_ESEL, 32'h0);
        rdChk(REG_STATUS, 32'hff04, 32'h5a00, "direct pick");
        access(1'b1, REG_FSEL, 32'h3, 4'h0);
        rdChk(REG_STATUS, 32'hff00, 32'h5a00, "byte lane off");
        wr(REG_FSEL, 32'h3);
        rdChk(REG_STATUS, 32'hff00, 32'h5f00, "direct release");
    endtask

    task automatic test_polled();
        queueAlmostFullN <= 4'h3;
        queueAlmostEmptyN <= 4'hc;
        wr(REG_CTRL, 32'h1);
        dev_pulse();
        repeat (3) begin
            @(posedge clk);
            @(negedge clk);
            chk("full slot", {fb.fullBusSync, fb.fullTokenOut, fb.almostFullLine}, 32'h33);
            chk("empty slot", {fb.emptyBusSync, fb.emptyTokenOut, fb.almostEmptyLine}, 32'h3c);
        end
        rdChk(REG_STATUS, 32'hffff18, 32'hc3c318, "polled status");
        wr(REG_FSEL, 32'h3);
        rdChk(REG_STATUS, 32'hff18, 32'hc318, "polled strobe");
        wr(REG_CTRL, 32'h0);
        dev_pulse();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("direct again", {fb.fullBusSync, fb.emptyBusSync, fb.almostFullOeN}, 32'h1);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_full();
        test_direct();
        test_polled();
        summarize();
    end

    // watchdog well beyond the roughly 130 cycles the scenarios take
    initial begin
        repeat (5000) @(posedge clk);
        errTotal++;
        summarize();
    end
endmodule

// [pkg/flag_bus_if.sv]
// Purpose: wires between one flag bus device and its controller
// Assumes: shared lines are pulled high when no end drives them
// Notes:   output enables are active low
interface flag_bus_if;
    import flag_bus_pkg::*;

    logic [WQ_ADDR_W-1:0] writeQueueAddr;
    logic                 writeAddrEnable;
    logic                 fullBusStrobe;
    logic [RQ_ADDR_W-1:0] readQueueAddr;
    logic                 emptyBusStrobe;
    logic                 flagBusModeSel;
    logic                 fullTokenIn;
    logic                 emptyTokenIn;
    logic                 writeQueueFullN;
    logic                 writeQueueFullOeN;
    logic [QUEUES-1:0]    almostFullBusN;
    logic                 almostFullOeN;
    logic [QUEUES-1:0]    almostEmptyBusN;
    logic                 almostEmptyOeN;
    logic                 fullBusSync;
    logic                 emptyBusSync;
    logic                 fullTokenOut;
    logic                 emptyTokenOut;
    logic                 serialProgDoneN;
    logic                 fullLine;
    logic [QUEUES-1:0]    almostFullLine;
    logic [QUEUES-1:0]    almostEmptyLine;

    // resolved level of the shared lines, pulled high when floating
    assign fullLine        = writeQueueFullOeN ? 1'b1 : writeQueueFullN;
    assign almostFullLine  = almostFullOeN ? {QUEUES{1'b1}} : almostFullBusN;
    assign almostEmptyLine = almostEmptyOeN ? {QUEUES{1'b1}} : almostEmptyBusN;

    modport dev (
        input  writeQueueAddr, writeAddrEnable, fullBusStrobe, readQueueAddr,
        input  emptyBusStrobe, flagBusModeSel, fullTokenIn, emptyTokenIn,
        output writeQueueFullN, writeQueueFullOeN, almostFullBusN, almostFullOeN,
        output almostEmptyBusN, almostEmptyOeN, fullBusSync, emptyBusSync,
        output fullTokenOut, emptyTokenOut, serialProgDoneN
    );

    modport ctl (
        output writeQueueAddr, writeAddrEnable, fullBusStrobe, readQueueAddr,
        output emptyBusStrobe, flagBusModeSel, fullTokenIn, emptyTokenIn,
        input  fullLine, almostFullLine, almostEmptyLine, fullBusSync,
        input  emptyBusSync, fullTokenOut, emptyTokenOut, serialProgDoneN
    );
endinterface

// [pkg/flag_bus_pkg.sv]
// Purpose: shared constants for the queue flag bus device and its controller
// Assumes: one clock drives both the write side and the read side
// Notes:   controller register map sits on Avalon-MM, 32-bit words
//
// Summary of operation
// - empty token out pulses while presenting status
// - empty token in loads status next edge
// - system loops token outputs into a ring
// - full flag follows newly selected write queue
// - writer writes after selection, only when not full
// - full flag drives only when selected, floats otherwise
// - full flag starts driving the cycle after selection
// - mode latched at reset: high polled, low direct
// - mode input held constant after reset
// - direct mode: strobe plus address picks bus owner
// - polled mode: full bus strobe held low
// - no full strobe before programming done
// - polled: successive edges load successive devices
// - full sync high while own status shown
// - single polled device: full token looped back
// - single direct device: full token input low
// - chained direct: first full token input low
// - full token out pulses while presenting status
// - empty sync high while own status shown
// - polled mode: empty bus strobe held low
package flag_bus_pkg;

    localparam int QUEUES    = 4;
    localparam int DEV_ID_W  = 3;
    localparam int WQ_ADDR_W = 5;
    localparam int RQ_ADDR_W = 6;
    localparam int WQ_SEL_W  = 2;
    localparam int RQ_SEL_W  = 3;

    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_WSEL   = 5'h04;
    localparam logic [4:0] REG_FSEL   = 5'h08;
    localparam logic [4:0] REG_ESEL   = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;

    localparam int CTRL_POLLED_BIT = 0;
    localparam int ST_FF_BIT       = 0;
    localparam int ST_WROK_BIT     = 1;
    localparam int ST_PROGN_BIT    = 2;
    localparam int ST_FULL_BUS_SYNC_BIT    = 3;
    localparam int ST_EMPTY_BUS_SYNC_BIT    = 4;
    localparam int ST_AF_POS       = 8;
    localparam int ST_AE_POS       = 12;
    localparam int ST_AFSNAP_POS   = 16;
    localparam int ST_AESNAP_POS   = 20;

    localparam logic       RST_POLLED = 1'b0;
    localparam logic [3:0] RST_BUS    = 4'hf;

endpackage
